// ===== hdl/pio_defs.svh
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the byte-wide register port.
// ----------------------------------------------------------------------
`define PIO_OFS_A_DATA  8'h00
`define PIO_OFS_C_DATA  8'h02
`define PIO_OFS_D_DATA  8'h03
`define PIO_OFS_A_DIR   8'h04
`define PIO_OFS_C_DIR   8'h06
`define PIO_OFS_D_DIR   8'h07
`define PIO_OFS_E_DATA  8'h08
`define PIO_OFS_E_DIR   8'h0c
`define PIO_OFS_A_PULL  8'h0d
`define PIO_OFS_C_PULL  8'h0e
`define PIO_OFS_D_PULL  8'h0f
`define PIO_OFS_KEY_EN  8'h10

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define PIO_DIR_RST     8'h00
`define PIO_PULL_RST    8'h00
`define PIO_KEY_EN_RST  8'h00
`define PIO_RD_RST      8'h00

// ----------------------------------------------------------------------
// Pin populations and field positions.
// ----------------------------------------------------------------------
`define PIO_MASK_A      8'hff
`define PIO_MASK_C      8'h7f
`define PIO_MASK_D      8'hff
`define PIO_MASK_E      8'h3f
`define PIO_PULL_MASK_E 8'h00
`define PIO_SPI_PINS    4
`define PIO_TIM_BASE    4
`define PIO_TIM_CHANS   4

`endif

// ===== hdl/pio_pkg.sv
package pio_pkg;

  // ----------------------------------------------------------------------
  // Pin driver bundle of one port, one bit per pin.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pio_pins_t;

  // ----------------------------------------------------------------------
  // Register selected by an address.
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    REG_A_DATA,
    REG_C_DATA,
    REG_D_DATA,
    REG_E_DATA,
    REG_A_DIR,
    REG_C_DIR,
    REG_D_DIR,
    REG_E_DIR,
    REG_A_PULL,
    REG_C_PULL,
    REG_D_PULL,
    REG_KEY_EN,
    REG_NONE
  } pio_reg_t;

endpackage

// ===== hdl/pio_port_cell.sv
`timescale 1ns/1ps
`include "pio_defs.svh"

module pio_port_cell #(
  parameter logic [7:0] PIN_MASK  = 8'hff,
  parameter logic [7:0] PULL_MASK = 8'hff
) (
  input  wire logic              clock,
  input  wire logic              clockEn,
  input  wire logic              resetn,
  input  wire logic [7:0]        wrData,
  input  wire logic              latchWr,
  input  wire logic              dirWr,
  input  wire logic              pullWr,
  input  wire logic [7:0]        pinIn,
  input  wire logic [7:0]        forceIn,
  input  wire logic [7:0]        own,
  input  wire logic [7:0]        ownOut,
  input  wire logic [7:0]        ownOe,
  output pio_pkg::pio_pins_t     pins,
  output logic      [7:0]        readVal,
  output logic      [7:0]        latchQ,
  output logic      [7:0]        dirQ,
  output logic      [7:0]        pullQ
);

  logic [7:0] latchD;
  logic [7:0] dirD;
  logic [7:0] pullD;

  // ----------------------------------------------------------------------
  // Register next values.
  // ----------------------------------------------------------------------
  always_comb begin
    latchD = latchWr ? (wrData & PIN_MASK) : latchQ; // RL6
    dirD   = dirWr ? (wrData & PIN_MASK) : dirQ;
    pullD  = pullWr ? (wrData & PIN_MASK & PULL_MASK) : pullQ;
  end

  // The data latch has no reset on purpose: its contents survive reset.
  always_ff @(posedge clock) begin
    if (clockEn) begin
      latchQ <= latchD; // RL1 RL4
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dirQ  <= `PIO_DIR_RST; // RL3 RL14
      pullQ <= `PIO_PULL_RST;
    end else if (clockEn) begin
      dirQ  <= dirD;
      pullQ <= pullD;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers and read-back.
  // ----------------------------------------------------------------------
  always_comb begin
    pins.oe   = (own & ownOe) | (~own & dirQ & ~forceIn); // RL2 RL14
    pins.oe   = pins.oe & PIN_MASK;
    pins.out  = ((own & ownOut) | (~own & latchQ)) & PIN_MASK; // RL15
    pins.pull = pullQ & ~pins.oe & PULL_MASK; // RL8
    readVal   = ((latchQ & dirQ) | (pinIn & ~dirQ)) & PIN_MASK; // RL5
  end

endmodule

// ===== hdl/pio_ports.sv
// What this block does
// RL1 - Port A has a separate data latch per pin at the first location.
// RL2 - A direction bit of one enables the output driver, zero disables it.
// RL3 - Reset clears every direction bit, so all pins start as inputs.
// RL4 - Reset leaves the data latches untouched; their contents are undefined.
// RL5 - Reads return latch where direction is one, pin level where zero.
// RL6 - Writes always update the latch; input pin reads still show the pin.
// RL7 - A port A pin acts as keyboard input when its enable bit is set.
// RL8 - Pullups on A, C, D connect only for enabled input pins.
// RL9 - Port C is seven bidirectional pins with latch, direction, pullup.
// RL10 - Port D has eight pins shared with serial interface and timers.
// RL11 - Timer edge/level select bits hand each timer pin to its channel.
// RL12 - Serial interface disabled returns its port D pins to port control.
// RL13 - Software writes the latch before turning a pin into an output.
// RL14 - Port E has six pins; zero direction means high impedance.
// RL15 - The latch drives a pin only when no peripheral owns it.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "pio_defs.svh"

module pio_ports (
  input  wire logic              clock,
  input  wire logic              clockEn,
  input  wire logic              resetn,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdData,
  input  wire logic [7:0]        portAIn,
  output pio_pkg::pio_pins_t     portAPins,
  input  wire logic [7:0]        portCIn,
  output pio_pkg::pio_pins_t     portCPins,
  input  wire logic [7:0]        portDIn,
  output pio_pkg::pio_pins_t     portDPins,
  input  wire logic [7:0]        portEIn,
  output pio_pkg::pio_pins_t     portEPins,
  output logic      [7:0]        keyboardInputs,
  input  wire logic              serialPeriphEnable,
  input  wire logic [3:0]        spiOut,
  input  wire logic [3:0]        spiOe,
  input  wire logic [3:0]        edgeLevelSelectHigh,
  input  wire logic [3:0]        edgeLevelSelectLow,
  input  wire logic [3:0]        timerOut,
  input  wire logic [3:0]        timerOe
);

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  function automatic pio_pkg::pio_reg_t decodeReg(input logic [7:0] a);
    case (a)
      `PIO_OFS_A_DATA: decodeReg = pio_pkg::REG_A_DATA;
      `PIO_OFS_C_DATA: decodeReg = pio_pkg::REG_C_DATA;
      `PIO_OFS_D_DATA: decodeReg = pio_pkg::REG_D_DATA;
      `PIO_OFS_E_DATA: decodeReg = pio_pkg::REG_E_DATA;
      `PIO_OFS_A_DIR:  decodeReg = pio_pkg::REG_A_DIR;
      `PIO_OFS_C_DIR:  decodeReg = pio_pkg::REG_C_DIR;
      `PIO_OFS_D_DIR:  decodeReg = pio_pkg::REG_D_DIR;
      `PIO_OFS_E_DIR:  decodeReg = pio_pkg::REG_E_DIR;
      `PIO_OFS_A_PULL: decodeReg = pio_pkg::REG_A_PULL;
      `PIO_OFS_C_PULL: decodeReg = pio_pkg::REG_C_PULL;
      `PIO_OFS_D_PULL: decodeReg = pio_pkg::REG_D_PULL;
      `PIO_OFS_KEY_EN: decodeReg = pio_pkg::REG_KEY_EN;
      default:         decodeReg = pio_pkg::REG_NONE;
    endcase
  endfunction

  pio_pkg::pio_reg_t wrSel;
  pio_pkg::pio_reg_t rdSel;
  logic              wrTaken;
  logic              rdTaken;

  // Strobes are ignored while the clock enable is low, like all other state.
  assign wrTaken = regWr && clockEn;
  assign rdTaken = regRd && clockEn;
  assign wrSel   = decodeReg(regAddr);
  assign rdSel   = decodeReg(regAddr);

  // ----------------------------------------------------------------------
  // Port cells.
  // ----------------------------------------------------------------------
  logic [7:0] aRead, aLatchQ, aDirQ, aPullQ;
  logic [7:0] cRead, cLatchQ, cDirQ, cPullQ;
  logic [7:0] dRead, dLatchQ, dDirQ, dPullQ;
  logic [7:0] eRead, eLatchQ, eDirQ;
  logic [7:0] keyIrqEnQ;
  logic [7:0] keyIrqEnD;
  logic [7:0] dOwn;
  logic [7:0] dOwnOut;
  logic [7:0] dOwnOe;

  // Keyboard enable forces the pin to be an input regardless of direction.
  pio_port_cell #(.PIN_MASK(`PIO_MASK_A), .PULL_MASK(`PIO_MASK_A)) u_portA (
    .clock   (clock),
    .clockEn (clockEn),
    .resetn  (resetn),
    .wrData  (regWrData),
    .latchWr (wrTaken && wrSel == pio_pkg::REG_A_DATA), // RL1
    .dirWr   (wrTaken && wrSel == pio_pkg::REG_A_DIR),
    .pullWr  (wrTaken && wrSel == pio_pkg::REG_A_PULL),
    .pinIn   (portAIn),
    .forceIn (keyIrqEnQ), // RL7
    .own     (8'h00),
    .ownOut  (8'h00),
    .ownOe   (8'h00),
    .pins    (portAPins),
    .readVal (aRead),
    .latchQ  (aLatchQ),
    .dirQ    (aDirQ),
    .pullQ   (aPullQ)
  );

  pio_port_cell #(.PIN_MASK(`PIO_MASK_C), .PULL_MASK(`PIO_MASK_C)) u_portC (
    .clock   (clock),
    .clockEn (clockEn),
    .resetn  (resetn),
    .wrData  (regWrData),
    .latchWr (wrTaken && wrSel == pio_pkg::REG_C_DATA), // RL9
    .dirWr   (wrTaken && wrSel == pio_pkg::REG_C_DIR),
    .pullWr  (wrTaken && wrSel == pio_pkg::REG_C_PULL),
    .pinIn   (portCIn),
    .forceIn (8'h00),
    .own     (8'h00),
    .ownOut  (8'h00),
    .ownOe   (8'h00),
    .pins    (portCPins),
    .readVal (cRead),
    .latchQ  (cLatchQ),
    .dirQ    (cDirQ),
    .pullQ   (cPullQ)
  );

  // Serial interface pins sit low, timer channels above them.
  assign dOwn[`PIO_SPI_PINS-1:0]    = {`PIO_SPI_PINS{serialPeriphEnable}};
  assign dOwnOut[`PIO_SPI_PINS-1:0] = spiOut; // RL10
  assign dOwnOe[`PIO_SPI_PINS-1:0]  = spiOe; // RL12

  for (genvar ch = 0; ch < `PIO_TIM_CHANS; ch++) begin : g_tim
    // Any nonzero edge/level select setting takes the pin for the channel.
    assign dOwn[`PIO_TIM_BASE+ch] =
      edgeLevelSelectHigh[ch] | edgeLevelSelectLow[ch]; // RL11
    assign dOwnOut[`PIO_TIM_BASE+ch] = timerOut[ch];
    assign dOwnOe[`PIO_TIM_BASE+ch]  = timerOe[ch];
  end

  pio_port_cell #(.PIN_MASK(`PIO_MASK_D), .PULL_MASK(`PIO_MASK_D)) u_portD (
    .clock   (clock),
    .clockEn (clockEn),
    .resetn  (resetn),
    .wrData  (regWrData),
    .latchWr (wrTaken && wrSel == pio_pkg::REG_D_DATA),
    .dirWr   (wrTaken && wrSel == pio_pkg::REG_D_DIR),
    .pullWr  (wrTaken && wrSel == pio_pkg::REG_D_PULL),
    .pinIn   (portDIn),
    .forceIn (8'h00),
    .own     (dOwn), // RL15
    .ownOut  (dOwnOut),
    .ownOe   (dOwnOe),
    .pins    (portDPins),
    .readVal (dRead),
    .latchQ  (dLatchQ),
    .dirQ    (dDirQ),
    .pullQ   (dPullQ)
  );

  // Port E has no pullups, so its pull mask is empty.
  pio_port_cell #(.PIN_MASK(`PIO_MASK_E), .PULL_MASK(`PIO_PULL_MASK_E)) u_portE (
    .clock   (clock),
    .clockEn (clockEn),
    .resetn  (resetn),
    .wrData  (regWrData),
    .latchWr (wrTaken && wrSel == pio_pkg::REG_E_DATA),
    .dirWr   (wrTaken && wrSel == pio_pkg::REG_E_DIR), // RL14
    .pullWr  (1'b0),
    .pinIn   (portEIn),
    .forceIn (8'h00),
    .own     (8'h00),
    .ownOut  (8'h00),
    .ownOe   (8'h00),
    .pins    (portEPins),
    .readVal (eRead),
    .latchQ  (eLatchQ),
    .dirQ    (eDirQ),
    .pullQ   ()
  );

  assign keyboardInputs = portAIn & keyIrqEnQ; // RL7

  // ----------------------------------------------------------------------
  // Keyboard enables and read data.
  // ----------------------------------------------------------------------
  logic [7:0] rdDataD;
  logic [7:0] rdDataQ;

  always_comb begin
    keyIrqEnD = keyIrqEnQ;
    if (wrTaken && wrSel == pio_pkg::REG_KEY_EN) begin
      keyIrqEnD = regWrData;
    end
    rdDataD = `PIO_RD_RST;
    if (rdTaken) begin
      case (rdSel)
        pio_pkg::REG_A_DATA: rdDataD = aRead; // RL5
        pio_pkg::REG_C_DATA: rdDataD = cRead;
        pio_pkg::REG_D_DATA: rdDataD = dRead;
        pio_pkg::REG_E_DATA: rdDataD = eRead;
        pio_pkg::REG_A_DIR:  rdDataD = aDirQ;
        pio_pkg::REG_C_DIR:  rdDataD = cDirQ;
        pio_pkg::REG_D_DIR:  rdDataD = dDirQ;
        pio_pkg::REG_E_DIR:  rdDataD = eDirQ; // RL14
        pio_pkg::REG_A_PULL: rdDataD = aPullQ;
        pio_pkg::REG_C_PULL: rdDataD = cPullQ;
        pio_pkg::REG_D_PULL: rdDataD = dPullQ;
        pio_pkg::REG_KEY_EN: rdDataD = keyIrqEnQ;
        default:             rdDataD = `PIO_RD_RST;
      endcase
    end
  end

  // Read data is zero outside the answer cycle while the clock enable is high; a low clock enable holds the last value.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      keyIrqEnQ <= `PIO_KEY_EN_RST;
      rdDataQ   <= `PIO_RD_RST;
    end else if (clockEn) begin
      keyIrqEnQ <= keyIrqEnD;
      rdDataQ   <= rdDataD;
    end
  end

  assign regRdData = rdDataQ;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cbDefault @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence seqWriteA;
    clockEn && regWr && regAddr == `PIO_OFS_A_DATA;
  endsequence

  sequence seqReadA;
    clockEn && regRd && regAddr == `PIO_OFS_A_DATA;
  endsequence

  chk_latch_to_pin: assert property ( // RL1
    seqWriteA ##1 (aDirQ == 8'hff && keyIrqEnQ == 8'h00)
      |-> portAPins.out == $past(regWrData))
    else $error("port A latch write did not reach the pins");

  chk_read_mux_a: assert property ( // RL5
    seqReadA |=> regRdData == (($past(aLatchQ) & $past(aDirQ)) |
                               ($past(portAIn) & ~$past(aDirQ))))
    else $error("port A read did not mix latch and pin by direction");

  chk_input_write_hidden: assert property ( // RL6
    seqWriteA ##1 (seqReadA and aDirQ == 8'h00)
      |=> regRdData == $past(portAIn) && aLatchQ == $past(regWrData, 2))
    else $error("write to input port A changed its read value");

  chk_dir_after_reset: assert property ( // RL3
    $rose(resetn) |-> aDirQ == 8'h00 && cDirQ == 8'h00 &&
                      dDirQ == 8'h00 && eDirQ == 8'h00)
    else $error("direction bits not cleared by reset");

  chk_oe_from_dir: assert property ( // RL2
    portAPins.oe == (aDirQ & ~keyIrqEnQ) && portCPins.oe == cDirQ)
    else $error("output enable does not follow direction");

  chk_key_forces_in: assert property ( // RL7
    (keyIrqEnQ & portAPins.oe) == 8'h00 &&
    keyboardInputs == (portAIn & keyIrqEnQ))
    else $error("keyboard pin not an input or not forwarded");

  chk_pullup_inputs: assert property ( // RL8
    (portAPins.pull & portAPins.oe) == 8'h00 &&
    (portCPins.pull & portCPins.oe) == 8'h00 &&
    (portDPins.pull & portDPins.oe) == 8'h00 &&
    portCPins.pull == (cPullQ & ~cDirQ))
    else $error("pullup connected on an output pin");

  chk_spi_release: assert property ( // RL12
    !serialPeriphEnable |-> portDPins.out[3:0] === dLatchQ[3:0] &&
                            portDPins.oe[3:0] == dDirQ[3:0])
    else $error("serial pins not returned to port control");

  chk_timer_owns_pin: assert property ( // RL11
    (edgeLevelSelectHigh[0] || edgeLevelSelectLow[0])
      |-> portDPins.oe[4] == timerOe[0] && portDPins.out[4] == timerOut[0])
    else $error("timer channel did not take its pin");

  chk_port_e_hiz: assert property ( // RL14
    (portEPins.oe & ~eDirQ) == 8'h00 && portEPins.pull == 8'h00 &&
    portEPins.oe[7:6] == 2'h0)
    else $error("port E drives a pin with direction zero");

  chk_unmapped_zero: assert property (
    (rdTaken && rdSel == pio_pkg::REG_NONE) |=> regRdData == 8'h00)
    else $error("unmapped read returned nonzero data");

  chk_clock_freeze: assert property (
    !clockEn |=> $stable(aDirQ) && $stable(keyIrqEnQ) && $stable(regRdData))
    else $error("state changed while clock enable was low");

endmodule

// ===== verif/pio_pin_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// External circuitry on one port: drives only pins the block leaves off.
// ----------------------------------------------------------------------
module pio_pin_model (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  pio_pkg::pio_pins_t      pins,
  input  wire logic [7:0]         extVal,
  input  wire logic [7:0]         extEn,
  output logic      [7:0]         level
);
  logic [7:0] last_q;

  // A floating line shows the inverse of its last level, so a read of an
  // undriven pin never matches by luck.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pins.oe[i]) begin
        level[i] = pins.out[i];
      end else if (extEn[i]) begin
        level[i] = extVal[i];
      end else if (pins.pull[i]) begin
        level[i] = 1'b1;
      end else begin
        level[i] = ~last_q[i];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_q <= 8'h00;
    end else begin
      last_q <= level;
    end
  end
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
`include "pio_defs.svh"

module tb;
  logic               clock, clockEn, resetn, regWr, regRd;
  logic               serialPeriphEnable;
  logic [7:0]         regAddr, regWrData, regRdData, keyboardInputs;
  logic [7:0]         portAIn, portCIn, portDIn, portEIn;
  logic [3:0][7:0]    extVal, extEn;
  logic [3:0]         spiOut, spiOe, elsHigh, elsLow, timerOut, timerOe;
  pio_pkg::pio_pins_t portAPins, portCPins, portDPins, portEPins;
  int                 n_fail, samples_checked, cycles;

  pio_ports i_pio_ports (.clock(clock), .clockEn(clockEn), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .portAIn(portAIn), .portAPins(portAPins),
    .portCIn(portCIn), .portCPins(portCPins), .portDIn(portDIn),
    .portDPins(portDPins), .portEIn(portEIn), .portEPins(portEPins),
    .keyboardInputs(keyboardInputs), .serialPeriphEnable(serialPeriphEnable),
    .spiOut(spiOut), .spiOe(spiOe), .edgeLevelSelectHigh(elsHigh),
    .edgeLevelSelectLow(elsLow), .timerOut(timerOut), .timerOe(timerOe));

  pio_pin_model i_pio_pin_model_a (.clock(clock), .resetn(resetn),
    .pins(portAPins), .extVal(extVal[0]), .extEn(extEn[0]), .level(portAIn));
  pio_pin_model i_pio_pin_model_c (.clock(clock), .resetn(resetn),
    .pins(portCPins), .extVal(extVal[1]), .extEn(extEn[1]), .level(portCIn));
  pio_pin_model i_pio_pin_model_d (.clock(clock), .resetn(resetn),
    .pins(portDPins), .extVal(extVal[2]), .extEn(extEn[2]), .level(portDIn));
  pio_pin_model i_pio_pin_model_e (.clock(clock), .resetn(resetn),
    .pins(portEPins), .extVal(extVal[3]), .extEn(extEn[3]), .level(portEIn));

  // ----------------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, exp, input string what);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    check(what, regRdData, exp);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_reset_vals();
    check("oe A", portAPins.oe, 8'h00);
    check("oe D", portDPins.oe, 8'h00);
    rd(`PIO_OFS_A_DIR, 8'h00, "dir A");
    rd(`PIO_OFS_C_DIR, 8'h00, "dir C");
    rd(`PIO_OFS_E_DIR, 8'h00, "dir E");
    rd(8'h01, 8'h00, "unmapped");
  endtask

  task automatic t_port_a();
    wr(`PIO_OFS_A_DATA, 8'ha5);
    wr(`PIO_OFS_A_DIR, 8'h0f);
    check("oe A", portAPins.oe, 8'h0f);
    check("out A", portAPins.out & 8'h0f, 8'h05);
    rd(`PIO_OFS_A_DATA, 8'h35, "rd A mixed");
    wr(`PIO_OFS_A_DATA, 8'hff);
    rd(`PIO_OFS_A_DATA, 8'h3f, "rd A input kept");
    extEn[0] <= 8'h00;
    wr(`PIO_OFS_A_PULL, 8'hff);
    check("pull A", portAPins.pull, 8'hf0);
    rd(`PIO_OFS_A_DATA, 8'hff, "rd A pulled");
    wr(`PIO_OFS_KEY_EN, 8'h01);
    check("oe A key", portAPins.oe, 8'h0e);
    check("key in", keyboardInputs, 8'h01);
    wr(`PIO_OFS_KEY_EN, 8'h00);
    extEn[0] <= 8'hff;
  endtask

  task automatic t_port_c();
    wr(`PIO_OFS_C_DATA, 8'h55);
    wr(`PIO_OFS_C_DIR, 8'hff);
    rd(`PIO_OFS_C_DIR, 8'h7f, "dir C width");
    check("oe C", portCPins.oe, 8'h7f);
    check("out C", portCPins.out, 8'h55);
    rd(`PIO_OFS_C_DATA, 8'h55, "rd C latch");
    wr(`PIO_OFS_C_DIR, 8'h00);
    wr(`PIO_OFS_C_PULL, 8'h03);
    check("pull C", portCPins.pull, 8'h03);
  endtask

  task automatic t_port_d();
    wr(`PIO_OFS_D_DATA, 8'hff);
    serialPeriphEnable <= 1'b1;
    spiOut <= 4'ha;
    spiOe <= 4'hf;
    elsHigh <= 4'b0001;
    elsLow <= 4'b0010;
    timerOut <= 4'h5;
    timerOe <= 4'hf;
    @(posedge clock);
    #1;
    check("oe D owned", portDPins.oe, 8'h3f);
    check("out D owned", portDPins.out & 8'h3f, 8'h1a);
    serialPeriphEnable <= 1'b0;
    elsHigh <= 4'h0;
    elsLow <= 4'h0;
    @(posedge clock);
    #1;
    check("oe D free", portDPins.oe, 8'h00);
    wr(`PIO_OFS_D_DIR, 8'h0f);
    check("out D free", portDPins.out & 8'h0f, 8'h0f);
    wr(`PIO_OFS_D_PULL, 8'hff);
    check("pull D", portDPins.pull, 8'hf0);
  endtask

  task automatic t_port_e();
    wr(`PIO_OFS_E_DATA, 8'h2a);
    wr(`PIO_OFS_E_DIR, 8'hff);
    rd(`PIO_OFS_E_DIR, 8'h3f, "dir E width");
    check("oe E", portEPins.oe, 8'h3f);
    check("out E", portEPins.out, 8'h2a);
    rd(`PIO_OFS_E_DATA, 8'h2a, "rd E latch");
    wr(`PIO_OFS_E_DIR, 8'h00);
    check("oe E off", portEPins.oe, 8'h00);
    check("pull E", portEPins.pull, 8'h00);
    rd(`PIO_OFS_E_DATA, 8'h03, "rd E pin");
  endtask

  // A write followed at once by a read must leave an input pin's read alone.
  task automatic t_back_to_back();
    wr(`PIO_OFS_A_DIR, 8'h00);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= `PIO_OFS_A_DATA;
    regWrData <= 8'h5a;
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    check("rd A after write", regRdData, 8'h3c);
    wr(`PIO_OFS_A_DIR, 8'hff);
    rd(`PIO_OFS_A_DATA, 8'h5a, "latch A hidden write");
    wr(`PIO_OFS_A_DATA, 8'hff);
    check("out A all", portAPins.out, 8'hff);
  endtask

  // A write strobe while the clock enable is low must be ignored.
  task automatic t_freeze();
    @(posedge clock);
    clockEn <= 1'b0;
    wr(`PIO_OFS_A_DIR, 8'h00);
    clockEn <= 1'b1;
    check("oe A frozen", portAPins.oe, 8'hff);
    rd(`PIO_OFS_A_DIR, 8'hff, "dir A frozen");
  endtask

  // The latch keeps its value across reset; direction, pullup and keyboard enable bits clear.
  task automatic t_reset_latch();
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(`PIO_OFS_A_DIR, 8'h00, "dir A after reset");
    wr(`PIO_OFS_A_DIR, 8'hff);
    rd(`PIO_OFS_A_DATA, 8'hff, "latch A kept");
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    clockEn = 1'b1;
    resetn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    serialPeriphEnable = 1'b0;
    {spiOut, spiOe, elsHigh, elsLow, timerOut, timerOe} = '0;
    extVal = {8'hc3, 8'h3c, 8'h00, 8'h3c};
    extEn = {4{8'hff}};
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    t_reset_vals();
    t_port_a();
    t_port_c();
    t_port_d();
    t_port_e();
    t_back_to_back();
    t_freeze();
    t_reset_latch();
    close_out();
  end
endmodule
